// >>> design/input_sync.sv
// Three-stage synchroniser with a two-stage agreement filter for pin inputs.
// Assumes the input is asynchronous to sys_clk.
`timescale 1ns/100ps
module input_sync #(
  parameter int W = 9
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Data
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] syncOut
);
  import thc_pkg::*;

  logic [W-1:0] s1_ff, s2_ff, s3_ff, out_ff;
  logic [W-1:0] nxt_out;

  // First stage feeds only the second stage
  always_comb begin
    nxt_out = out_ff;
    for (int i = 0; i < W; i++) begin
      if (s2_ff[i] == s3_ff[i]) begin
        nxt_out[i] = s2_ff[i];
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      out_ff <= '0;
    end else begin
      s1_ff <= pinIn;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      out_ff <= nxt_out;
    end
  end

  assign syncOut = out_ff;
endmodule : input_sync

// >>> design/thc_pkg.sv
// Shared types and timing constants for the two-hand control block.
// Assumes a single 40 MHz scan clock and pin inputs from outside that domain.
package thc_pkg;
  localparam int NUM_STATIONS = 4;
  localparam int CLK_HZ = 40_000_000;
  localparam int SIMUL_WINDOW_S = 3;
  localparam int SIMUL_CYCLES = SIMUL_WINDOW_S * CLK_HZ;
  localparam int SIMUL_W = 27;
  localparam int SYNC_STAGES = 3;

  typedef struct packed {
    logic [NUM_STATIONS-1:0] stationRun;
    logic safeguardRun;
    logic bypassRun;
    logic muteChanA;
    logic muteChanB;
    logic mutePermit;
  } thc_inputs_t;

  typedef struct packed {
    logic bypassEnable;
    logic muteUsed;
    logic permitMapped;
    logic [NUM_STATIONS-1:0] muteSelect;
  } thc_config_t;

  typedef struct packed {
    logic blockOut;
    logic bypassOut;
    logic safetyOut;
    logic muted;
  } thc_status_t;
endpackage : thc_pkg

// >>> design/two_hand_control_with_muting.sv
// Two-hand control decision with bypass, optical safeguard and station muting.
// Assumes pin inputs are asynchronous; configuration is static during operation.
`timescale 1ns/100ps
module two_hand_control_with_muting (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Field pins
  input wire thc_pkg::thc_inputs_t pins,
  // Static configuration
  input wire thc_pkg::thc_config_t cfg,
  // Results
  output thc_pkg::thc_status_t status
);
  import thc_pkg::*;

  localparam int IW = $bits(thc_inputs_t);

  thc_inputs_t in;
  logic [IW-1:0] syncBits;

  input_sync #(.W(IW)) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pinIn(pins),
    .syncOut(syncBits)
  );
  assign in = thc_inputs_t'(syncBits);

  typedef enum logic [1:0] {MS_IDLE, MS_ONE, MS_BLOCKED, MS_MUTED} mute_state_t;

  mute_state_t muteSt_ff, nxt_muteSt;
  logic [SIMUL_W-1:0] simCnt_ff, nxt_simCnt;
  logic armed_ff, nxt_armed;
  logic blockOut_ff, nxt_blockOut;
  logic bypassOut_ff, nxt_bypassOut;
  logic safetyOut_ff, nxt_safetyOut;
  logic prevReady_ff, nxt_prevReady;
  logic prevSafe_ff, nxt_prevSafe;

  function automatic logic allRun(input logic [NUM_STATIONS-1:0] v,
                                  input logic [NUM_STATIONS-1:0] need);
    allRun = ((v & need) == need);
  endfunction : allRun

  // Station 0 is the one that may be bypassed; the rest always count
  logic [NUM_STATIONS-1:0] needMask;
  logic anyMute, bothMute, bypassOk, handsReady, heldMute;
  always_comb begin
    needMask = '1;
    if (cfg.bypassEnable) begin
      needMask[0] = 1'b0;
    end
    anyMute = in.muteChanA | in.muteChanB;
    bothMute = in.muteChanA & in.muteChanB;
    bypassOk = !cfg.bypassEnable || (in.stationRun[0] ^ in.bypassRun);
    // Station 0 alone or the bypass switch alone completes the bypass group
    handsReady = allRun(in.stationRun, needMask) && bypassOk;
    // Selected stations may drop while muted; others keep turn-off authority.
    // A muted station 0 may leave the bypass group empty, but a conflict still stops.
    heldMute = (muteSt_ff == MS_MUTED)
               && allRun(in.stationRun, needMask & ~cfg.muteSelect)
               && !(cfg.bypassEnable && in.stationRun[0] && in.bypassRun)
               && (cfg.muteSelect[0] || bypassOk);
  end

  // Mute sequencing; the window is counted in scan ticks
  always_comb begin
    nxt_muteSt = muteSt_ff;
    nxt_simCnt = simCnt_ff;
    unique case (muteSt_ff)
      MS_IDLE: begin
        nxt_simCnt = '0;
        if (cfg.muteUsed && anyMute) begin
          // Both at once counts as simultaneous
          if (bothMute && in.safeguardRun && blockOut_ff
              && (!cfg.permitMapped || in.mutePermit)) begin
            nxt_muteSt = MS_MUTED;
          end else if (bothMute) begin
            nxt_muteSt = MS_BLOCKED;
          end else begin
            nxt_muteSt = MS_ONE;
          end
        end
      end
      MS_ONE: begin
        nxt_simCnt = simCnt_ff + SIMUL_W'(1);
        if (!anyMute) begin
          nxt_muteSt = MS_IDLE;
        end else if (bothMute) begin
          if (in.safeguardRun && blockOut_ff && (!cfg.permitMapped || in.mutePermit)) begin
            nxt_muteSt = MS_MUTED;
          end else begin
            nxt_muteSt = MS_BLOCKED;
          end
        end else if (simCnt_ff >= SIMUL_W'(SIMUL_CYCLES - 1)) begin
          nxt_muteSt = MS_BLOCKED;
        end
      end
      MS_BLOCKED: begin
        // Stays blocked until every sensor clears, so a late pair cannot mute
        if (!anyMute) begin
          nxt_muteSt = MS_IDLE;
        end
      end
      MS_MUTED: begin
        // Permit is not rechecked here: dropping it mid-mute has no effect
        if (!bothMute || !in.safeguardRun) begin
          nxt_muteSt = anyMute ? MS_BLOCKED : MS_IDLE;
        end
      end
    endcase
  end

  // Synchroniser outputs read as stop until they fill; arming waits for them,
  // so a power-up with hands in run is not taken for a stop
  localparam int SETTLE_TICKS = SYNC_STAGES + 1;
  logic [2:0] settle_ff, nxt_settle;
  logic settled;
  always_comb begin
    settled = (settle_ff == 3'(SETTLE_TICKS));
    nxt_settle = settle_ff;
    if (!settled) begin
      nxt_settle = settle_ff + 3'h1;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      settle_ff <= '0;
    end else begin
      settle_ff <= nxt_settle;
    end
  end

  // Output decision
  logic startOk;
  always_comb begin
    nxt_prevReady = handsReady;
    nxt_prevSafe = in.safeguardRun;
    nxt_armed = armed_ff;
    // Power-up with hands in run keeps block and safety outputs off until a stop is seen
    if (settled && !handsReady) begin
      nxt_armed = 1'b1;
    end
    // Start on the hands' rising edge with safeguard already in run
    startOk = armed_ff && handsReady && !prevReady_ff && prevSafe_ff
              && in.safeguardRun;
    if (blockOut_ff) begin
      nxt_blockOut = in.safeguardRun && (handsReady || heldMute);
    end else begin
      nxt_blockOut = startOk;
    end
    nxt_bypassOut = cfg.bypassEnable && (in.stationRun[0] ^ in.bypassRun);
    nxt_safetyOut = nxt_blockOut;
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      muteSt_ff <= MS_IDLE;
      simCnt_ff <= '0;
      armed_ff <= 1'b0;
      blockOut_ff <= 1'b0;
      bypassOut_ff <= 1'b0;
      safetyOut_ff <= 1'b0;
      prevReady_ff <= 1'b1;
      prevSafe_ff <= 1'b0;
    end else begin
      muteSt_ff <= nxt_muteSt;
      simCnt_ff <= nxt_simCnt;
      armed_ff <= nxt_armed;
      blockOut_ff <= nxt_blockOut;
      bypassOut_ff <= nxt_bypassOut;
      safetyOut_ff <= nxt_safetyOut;
      prevReady_ff <= nxt_prevReady;
      prevSafe_ff <= nxt_prevSafe;
    end
  end

  logic muted_ff;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      muted_ff <= 1'b0;
    end else begin
      muted_ff <= (nxt_muteSt == MS_MUTED);
    end
  end

  assign status = '{
    blockOut: blockOut_ff,
    bypassOut: bypassOut_ff,
    safetyOut: safetyOut_ff,
    muted: muted_ff
  };

  a_safeguard_off: assert property (@(posedge sys_clk) disable iff (rst)
    !in.safeguardRun |=> !blockOut_ff) else $error("output on without safeguard");
  a_start_needs_guard: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(blockOut_ff) |-> $past(prevSafe_ff)) else $error("start without guard");
  a_bypass_conflict: assert property (@(posedge sys_clk) disable iff (rst)
    (cfg.bypassEnable && in.stationRun[0] && in.bypassRun) |=> !bypassOut_ff && !blockOut_ff)
    else $error("bypass conflict not forced off");
  a_bypass_exclusive: assert property (@(posedge sys_clk) disable iff (rst)
    bypassOut_ff |-> $past(in.stationRun[0] ^ in.bypassRun)) else $error("bypass not exclusive");
  a_powerup_hold: assert property (@(posedge sys_clk) disable iff (rst)
    !armed_ff |-> !blockOut_ff) else $error("output on before arming");
  a_follow_logic: assert property (@(posedge sys_clk) disable iff (rst)
    safetyOut_ff == blockOut_ff) else $error("safety output diverged");
  a_window_expiry: assert property (@(posedge sys_clk) disable iff (rst)
    (muteSt_ff == MS_ONE && simCnt_ff >= SIMUL_W'(SIMUL_CYCLES - 1) && !bothMute && anyMute)
    |=> muteSt_ff == MS_BLOCKED) else $error("window not enforced");
  a_blocked_no_mute: assert property (@(posedge sys_clk) disable iff (rst)
    muteSt_ff == MS_BLOCKED |=> muteSt_ff != MS_MUTED) else $error("muted after failure");
  a_mute_entry: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(muted_ff) |-> $past(bothMute && in.safeguardRun, 1)) else $error("bad mute entry");
  a_unselected_off: assert property (@(posedge sys_clk) disable iff (rst)
    (blockOut_ff && !allRun(in.stationRun, needMask & ~cfg.muteSelect)) |=> !blockOut_ff)
    else $error("unselected station lost authority");
  a_arm_needs_stop: assert property (@(posedge sys_clk) disable iff (rst)
    (!armed_ff && (!settled || handsReady)) |=> !armed_ff) else $error("armed without stop");
  a_permit_at_entry: assert property (@(posedge sys_clk) disable iff (rst)
    ($rose(muted_ff) && cfg.permitMapped) |-> $past(in.mutePermit)) else $error("mute without permit");
endmodule : two_hand_control_with_muting

// >>> tb/thc_field_model.sv
// Field-side model: operator stations, optical safeguard, bypass switch and mute sensors.
// Assumes the bench commands the levels; mute channel B may trail channel A.
`timescale 1ns/100ps
module thc_field_model (
  // Clock
  input wire logic sys_clk,
  // Commanded field levels
  input wire thc_pkg::thc_inputs_t want,
  input wire logic [7:0] lagB,
  // Pins towards the block
  output thc_pkg::thc_inputs_t pins
);
  import thc_pkg::*;
  logic [7:0] heldB_ff;
  logic [7:0] nxt_heldB;

  // Saturating count of how long channel B has been asked for
  always_comb begin
    nxt_heldB = heldB_ff;
    if (!want.muteChanB) begin
      nxt_heldB = 8'h00;
    end else if (heldB_ff != 8'hFF) begin
      nxt_heldB = heldB_ff + 8'h01;
    end
  end

  always_ff @(posedge sys_clk) begin
    heldB_ff <= nxt_heldB;
  end

  // A slow second sensor still lands well inside the window
  always_comb begin
    pins = want;
    pins.muteChanB = want.muteChanB && (heldB_ff >= lagB);
  end
endmodule : thc_field_model

// >>> tb/two_hand_control_with_muting_bench.sv
// Self-checking bench for the two-hand control block with muting.
// Assumes the field model in front of the pins; stations 2 and 3 stay in run except in row 9'h116, which drops station 2 (step 9'h1BE drops station 1).
`timescale 1ns/100ps
module two_hand_control_with_muting_bench;
  import thc_pkg::*;
  typedef struct packed {
    thc_inputs_t in;
    logic [3:0] exp;
    logic ckMute;
  } row_t;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  thc_inputs_t want = 9'h190;
  thc_config_t cfg = '{bypassEnable: 1'h1, muteUsed: 1'h1, permitMapped: 1'h1, muteSelect: 4'h3};
  logic [7:0] lagB = 8'h00;
  thc_inputs_t pins;
  thc_status_t status;
  int n_mismatch = 0;
  int checks_done = 0;
  // Stations, safeguard, bypass, chan A, chan B, permit -> block, bypass, safety, muted
  row_t rows [20] = '{
    '{9'h190, 4'h0, 1'h1}, '{9'h1F0, 4'hE, 1'h1}, '{9'h1E0, 4'h4, 1'h1},
    '{9'h1F0, 4'h4, 1'h1}, '{9'h190, 4'h0, 1'h1}, '{9'h1D8, 4'hE, 1'h1},
    '{9'h1F8, 4'h0, 1'h1}, '{9'h190, 4'h0, 1'h1}, '{9'h1F0, 4'hE, 1'h1},
    '{9'h1F7, 4'hF, 1'h1}, '{9'h197, 4'hB, 1'h1}, '{9'h196, 4'hB, 1'h1},
    '{9'h116, 4'h0, 1'h0}, '{9'h190, 4'h0, 1'h1}, '{9'h1F0, 4'hE, 1'h1},
    '{9'h1F6, 4'hE, 1'h1}, '{9'h196, 4'h0, 1'h1}, '{9'h190, 4'h0, 1'h1},
    '{9'h1E7, 4'h4, 1'h1}, '{9'h190, 4'h0, 1'h1}
  };

  always #12.5 sys_clk = ~sys_clk;

  thc_field_model field_u (.sys_clk(sys_clk), .want(want), .lagB(lagB), .pins(pins));

  two_hand_control_with_muting dut_u (
    .sys_clk(sys_clk),
    .rst(rst),
    .pins(pins),
    .cfg(cfg),
    .status(status)
  );

  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t status %b expected %b", $time, seen, exp);
    end
  endtask : check

  // Pins pass a synchroniser, so each step after reset release waits well past the pin-to-output latency
  task automatic apply(input thc_inputs_t v, input int n);
    want = v;
    repeat (n) @(posedge sys_clk);
    #2;
  endtask : apply

  task automatic finish_test();
    $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test

  initial begin
    #(3000 * 25);
    n_mismatch++;
    finish_test();
  end

  initial begin
    apply(9'h190, 5);
    check(status, 4'h0);
    rst = 1'b0;
    foreach (rows[i]) begin
      apply(rows[i].in, 10);
      check(status & {3'h7, rows[i].ckMute}, rows[i].exp);
    end
    // Power up with both hands already pressed
    rst = 1'b1;
    apply(9'h1F0, 3);
    rst = 1'b0;
    apply(9'h1F0, 12);
    check(status, 4'h4);
    apply(9'h190, 10);
    apply(9'h1F0, 10);
    check(status, 4'hE);
    // Second sensor trails by 100 scans, far inside the window
    lagB = 8'h64;
    apply(9'h1F7, 50);
    check(status, 4'hE);
    apply(9'h1F7, 80);
    check(status, 4'hF);
    apply(9'h190, 10);
    check(status, 4'h0);
    // No bypass block, permit unmapped, only station 0 may be muted
    rst = 1'b1;
    lagB = 8'h00;
    cfg = '{bypassEnable: 1'h0, muteUsed: 1'h1, permitMapped: 1'h0, muteSelect: 4'h1};
    apply(9'h190, 3);
    rst = 1'b0;
    apply(9'h190, 10);
    check(status, 4'h0);
    apply(9'h1F8, 10);
    check(status, 4'hA);
    apply(9'h1FE, 10);
    check(status, 4'hB);
    apply(9'h1DE, 10);
    check(status, 4'hB);
    apply(9'h1BE, 10);
    check(status, 4'h1);
    apply(9'h190, 10);
    check(status, 4'h0);
    // Mute sensor pair not mapped: sensors never hold the output
    rst = 1'b1;
    cfg = '{bypassEnable: 1'h0, muteUsed: 1'h0, permitMapped: 1'h0, muteSelect: 4'hF};
    apply(9'h190, 3);
    rst = 1'b0;
    apply(9'h190, 10);
    apply(9'h1F7, 10);
    check(status, 4'hA);
    apply(9'h197, 10);
    check(status, 4'h0);
    finish_test();
  end
endmodule : two_hand_control_with_muting_bench
